/* rtl/sdif_consts.vh */
// Purpose: shared constants of the slave diagnostic interrupt framer
// Assumes: byte offsets inside the diagnostic frame fit in 8 bits
// Notes: included by its bare name
`ifndef SDIF_CONSTS_VH
`define SDIF_CONSTS_VH

// Interrupt section limits and layout
`define SDIF_IRQ_MAX 8'd48
`define SDIF_IRQ_HDR 8'd4
`define SDIF_REC0_LEN 6'd4
`define SDIF_REC1_EXTRA 6'd40
`define SDIF_REC1_LEN 6'd44
`define SDIF_HW_LEN 8'd4
`define SDIF_PROC_LEN 8'd4
`define SDIF_SWAP_LEN 8'd5
`define SDIF_PROC_ZERO_A 8'd6
`define SDIF_PROC_ZERO_B 8'd7

// Interrupt type codes on irq_type
`define SDIF_T_DIAG 2'h0
`define SDIF_T_HW 2'h1
`define SDIF_T_PROC 2'h2
`define SDIF_T_SWAP 2'h3

// Channel-specific entries
`define SDIF_CHAN_MAX 4'd9
`define SDIF_CHAN_BYTES 8'd3

// Whole frame length budget
`define SDIF_FRAME_MAX 9'h0f4

// Configuration fault reporting
`define SDIF_SLOTS 17
`define SDIF_ST_FAULT 2'h1
`define SDIF_ST_NOMOD 2'h3

`endif

/* rtl/sdif_framer.v */
// Purpose: streams channel entries and the interrupt section of a slave diagnostic frame
// Assumes: all inputs come from logic on the same clock; records are written by I/O modules
// Notes: bytes leave on a valid/ready byte port with their frame offset
`timescale 1ns/10ps
`include "sdif_consts.vh"

// Function
// - interrupt section never exceeds 48 bytes
// - interrupt section follows channel or identifier data
// - pending interrupt drops channel entries to fit
// - module diagnostics at most 44 bytes, two records
// - record zero holds exactly 4 state bytes
// - record one repeats 4, adds 40 bytes
// - records come from modules, passed unchanged
// - diagnostic interrupt sends 44-byte record at x+4
// - hardware interrupt status is 4 bytes
// - swapping interrupt information is 5 bytes
// - digital process interrupt forces x+6, x+7 zero
// - configuration faults fail station regardless of parameter
// - configuration fault sets identifier bits slots 1-17
// - slots before failing slot report status 01
// - failing slot onward reports status 11
// - slave failure stops cyclic user data exchange
// - failed slave still frames diagnostics and records
// - master or slave events enter slave failure
// - each channel entry takes 3 bytes
// - at most 9 entries, overflow flag beyond
module sdif_framer (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Frame request and layout
    input wire frame_req,
    input wire [7:0] id_end_off,
    input wire [7:0] chan_base,
    // Channel entry store
    input wire chan_wr,
    input wire [3:0] chan_wr_idx,
    input wire [23:0] chan_wr_data,
    input wire [4:0] chan_pending,
    // Module record store
    input wire rec_wr,
    input wire [5:0] rec_wr_idx,
    input wire [7:0] rec_wr_data,
    // Pending interrupt
    input wire irq_pend,
    input wire [1:0] irq_type,
    input wire [7:0] irq_slot,
    input wire [7:0] irq_spec,
    input wire irq_dig8,
    // Configuration state
    input wire cfg_no_term,
    input wire cfg_too_many,
    input wire cfg_bus_fault,
    input wire [4:0] fail_slot,
    input wire [16:0] id_diag_in,
    input wire [33:0] mod_status_in,
    // Failure events
    input wire master_new_cfg,
    input wire master_conn_lost,
    input wire master_off,
    input wire xchg_restart,
    // Byte stream out
    input wire out_ready,
    output reg out_valid_reg,
    output reg [7:0] out_byte_reg,
    output reg [7:0] out_off_reg,
    output reg out_last_reg,
    // Frame results
    output reg frame_done_reg,
    output reg irq_sent_reg,
    output reg [7:0] irq_start_reg,
    output reg [3:0] chan_count_reg,
    output reg diag_overflow_reg,
    // Station state
    output reg failed_reg,
    output reg xchg_en_reg,
    output reg cfg_fault_reg,
    output reg [16:0] id_diag_reg,
    output reg [33:0] mod_status_reg
);

    // Sequencer states. Idle waits for a request and latches the pending
    // interrupt, calc trims channel entries one per cycle until the interrupt
    // section fits the frame budget, chan and irq stream bytes, and done
    // pulses the completion flags once the last byte has been accepted.
    // Trimming one entry per cycle keeps the adder chain short at the
    // price of a few idle cycles on an overfull frame; a frame with no
    // entries and no interrupt still passes through done.
    localparam S_IDLE = 3'h0;
    localparam S_CALC = 3'h1;
    localparam S_CHAN = 3'h2;
    localparam S_IRQ = 3'h3;
    localparam S_DONE = 3'h4;

    // Sequencer state and counters
    // n_reg: entries kept, ent_reg and k_reg: entry and byte within it
    // b_reg: index inside the interrupt section, off_reg: next frame offset
    reg [2:0] state_reg;
    reg [3:0] n_reg;
    reg [3:0] ent_reg;
    reg [1:0] k_reg;
    reg [7:0] b_reg;
    reg [7:0] off_reg;
    // Interrupt kind latched at the request, so a change on the
    // type input while streaming cannot tear the section apart
    reg irq_reg;
    reg [1:0] type_reg;
    reg [7:0] ilen_reg;
    // Storage for channel entries and the module's two records;
    // the records share one array since the second repeats the first
    reg [23:0] chan_mem [0:8];
    reg [7:0] rec_mem [0:43];

    // Any configuration fault counts, whatever the station parameters say
    wire cfg_fault = cfg_no_term | cfg_too_many | cfg_bus_fault;
    // A new byte may be loaded when the holding register is empty or drained
    wire take = ~out_valid_reg | out_ready;

    // Entry and record stores, filled only by the modules
    // The stores are not reset: the modules rewrite them before any frame,
    // and an out-of-range index is dropped rather than wrapped
    always @(posedge clock) begin
        if (chan_wr && chan_wr_idx < `SDIF_CHAN_MAX) begin
            chan_mem[chan_wr_idx] <= chan_wr_data;
        end
        if (rec_wr && rec_wr_idx < `SDIF_REC1_LEN) begin
            rec_mem[rec_wr_idx] <= rec_wr_data;
        end
    end

    // Interrupt section length by type, header included
    // The length byte counts the whole section, so a diagnostic interrupt
    // comes to the 48-byte ceiling exactly and no other kind exceeds it
    reg [7:0] ilen_w;
    always @* begin
        case (irq_type)
            `SDIF_T_DIAG: ilen_w = `SDIF_IRQ_HDR + {2'h0, `SDIF_REC1_LEN};
            `SDIF_T_HW: ilen_w = `SDIF_IRQ_HDR + `SDIF_HW_LEN;
            `SDIF_T_PROC: ilen_w = `SDIF_IRQ_HDR + `SDIF_PROC_LEN;
            default: ilen_w = `SDIF_IRQ_HDR + `SDIF_SWAP_LEN;
        endcase
    end

    // Start of interrupt section from the entries kept
    // Three bytes per entry, computed as 2n + n to avoid a multiplier
    // With no entries the section sits right behind the identifier bytes
    // The end sum is one bit wider so an overfull frame cannot wrap
    wire [7:0] chan_span = {3'h0, n_reg, 1'b0} + {4'h0, n_reg};
    wire [7:0] start_w = (n_reg == 4'h0) ? id_end_off : chan_base + chan_span;
    wire [8:0] end_w = {1'b0, start_w} + {1'b0, ilen_reg};
    wire too_long = irq_reg && (end_w > `SDIF_FRAME_MAX) && (n_reg != 4'h0);

    // Byte of the current channel entry
    // Entries leave most significant byte first
    reg [7:0] chan_byte_w;
    always @* begin
        case (k_reg)
            2'h0: chan_byte_w = chan_mem[ent_reg][23:16];
            2'h1: chan_byte_w = chan_mem[ent_reg][15:8];
            default: chan_byte_w = chan_mem[ent_reg][7:0];
        endcase
    end

    // Byte of the interrupt section at index b_reg
    // Header bytes first, then record bytes from index 4 on;
    // the digital process case masks two payload bytes to zero
    reg [7:0] irq_byte_w;
    reg [7:0] rec_i;
    always @* begin
        rec_i = b_reg - `SDIF_IRQ_HDR;
        case (b_reg)
            8'h00: irq_byte_w = ilen_reg;
            8'h01: irq_byte_w = {6'h00, type_reg};
            8'h02: irq_byte_w = irq_slot;
            8'h03: irq_byte_w = irq_spec;
            default: irq_byte_w = rec_mem[rec_i[5:0]];
        endcase
        if (type_reg == `SDIF_T_PROC && irq_dig8 &&
            (b_reg == `SDIF_PROC_ZERO_A || b_reg == `SDIF_PROC_ZERO_B)) begin
            irq_byte_w = 8'h00;
        end
    end

    // Frame sequencer, runs whether or not the slave has failed
    // Accepting a byte empties the holding register unless a new one is
    // loaded in the same cycle below
    always @(posedge clock) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            n_reg <= 4'h0;
            ent_reg <= 4'h0;
            k_reg <= 2'h0;
            b_reg <= 8'h00;
            off_reg <= 8'h00;
            irq_reg <= 1'b0;
            type_reg <= 2'h0;
            ilen_reg <= 8'h00;
            out_valid_reg <= 1'b0;
            out_byte_reg <= 8'h00;
            out_off_reg <= 8'h00;
            out_last_reg <= 1'b0;
            frame_done_reg <= 1'b0;
            irq_sent_reg <= 1'b0;
            irq_start_reg <= 8'h00;
            chan_count_reg <= 4'h0;
            diag_overflow_reg <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            irq_sent_reg <= 1'b0;
            if (out_valid_reg && out_ready) begin
                out_valid_reg <= 1'b0;
            end
            case (state_reg)
                S_IDLE: begin
                    if (frame_req) begin
                        diag_overflow_reg <= (chan_pending > {1'b0, `SDIF_CHAN_MAX});
                        n_reg <= (chan_pending > {1'b0, `SDIF_CHAN_MAX}) ?
                            `SDIF_CHAN_MAX : chan_pending[3:0];
                        irq_reg <= irq_pend;
                        type_reg <= irq_type;
                        ilen_reg <= ilen_w;
                        state_reg <= S_CALC;
                    end
                end
                // Drop one entry per cycle while the section would overrun
                S_CALC: begin
                    if (too_long) begin
                        n_reg <= n_reg - 4'h1;
                    end else begin
                        chan_count_reg <= n_reg;
                        irq_start_reg <= start_w;
                        ent_reg <= 4'h0;
                        k_reg <= 2'h0;
                        b_reg <= 8'h00;
                        off_reg <= chan_base;
                        if (n_reg != 4'h0) begin
                            state_reg <= S_CHAN;
                        end else if (irq_reg) begin
                            off_reg <= start_w;
                            state_reg <= S_IRQ;
                        end else begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_CHAN: begin
                    if (take) begin
                        out_valid_reg <= 1'b1;
                        out_byte_reg <= chan_byte_w;
                        out_off_reg <= off_reg;
                        off_reg <= off_reg + 8'h01;
                        if (k_reg == 2'h2) begin
                            k_reg <= 2'h0;
                            ent_reg <= ent_reg + 4'h1;
                            if (ent_reg + 4'h1 == n_reg) begin
                                out_last_reg <= ~irq_reg;
                                state_reg <= irq_reg ? S_IRQ : S_DONE;
                            end
                        end else begin
                            k_reg <= k_reg + 2'h1;
                        end
                    end
                end
                S_IRQ: begin
                    if (take) begin
                        out_valid_reg <= 1'b1;
                        out_byte_reg <= irq_byte_w;
                        out_off_reg <= off_reg;
                        off_reg <= off_reg + 8'h01;
                        b_reg <= b_reg + 8'h01;
                        out_last_reg <= (b_reg + 8'h01 == ilen_reg);
                        if (b_reg + 8'h01 == ilen_reg) begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                // Wait for the last byte to drain, then pulse completion
                S_DONE: begin
                    if (take) begin
                        out_valid_reg <= 1'b0;
                        out_last_reg <= 1'b0;
                        frame_done_reg <= 1'b1;
                        irq_sent_reg <= irq_reg;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Slave failure: set by any event, restart only when clean
    // An event in the restart cycle wins, so a restart cannot hide a fault
    // Cyclic exchange is allowed only while the slave is not failed
    wire fail_evt = master_new_cfg | master_conn_lost | master_off | cfg_fault;
    wire failed_next = fail_evt | (failed_reg & ~xchg_restart);
    always @(posedge clock) begin
        if (!nrst) begin
            failed_reg <= 1'b0;
            xchg_en_reg <= 1'b0;
            cfg_fault_reg <= 1'b0;
        end else begin
            failed_reg <= failed_next;
            xchg_en_reg <= ~failed_next;
            cfg_fault_reg <= cfg_fault;
        end
    end

    // Per slot identifier bit and module status
    // On a fault every identifier bit is set and slots before the failing
    // one read as faulty, the rest as missing; otherwise the module values
    // pass through one cycle late. Slot numbers start at one, so slot
    // gi + 1 is compared against the failing slot.
    genvar gi;
    generate
        for (gi = 0; gi < `SDIF_SLOTS; gi = gi + 1) begin : g_slot
            always @(posedge clock) begin
                if (!nrst) begin
                    id_diag_reg[gi] <= 1'b0;
                    mod_status_reg[2*gi+1:2*gi] <= 2'h0;
                end else if (cfg_fault) begin
                    id_diag_reg[gi] <= 1'b1;
                    if (gi + 1 < fail_slot) begin
                        mod_status_reg[2*gi+1:2*gi] <= `SDIF_ST_FAULT;
                    end else begin
                        mod_status_reg[2*gi+1:2*gi] <= `SDIF_ST_NOMOD;
                    end
                end else begin
                    id_diag_reg[gi] <= id_diag_in[gi];
                    mod_status_reg[2*gi+1:2*gi] <= mod_status_in[2*gi+1:2*gi];
                end
            end
        end
    endgenerate

endmodule // sdif_framer

/* testbench/sdif_checker.sv */
// Purpose: port assertions for sdif_framer
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module sdif_checker (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Inputs watched
    input wire out_ready,
    input wire irq_pend,
    input wire [1:0] irq_type,
    input wire irq_dig8,
    input wire cfg_no_term,
    input wire cfg_too_many,
    input wire cfg_bus_fault,
    input wire [4:0] fail_slot,
    // Outputs watched
    input wire out_valid_reg,
    input wire [7:0] out_byte_reg,
    input wire [7:0] out_off_reg,
    input wire out_last_reg,
    input wire frame_done_reg,
    input wire [7:0] irq_start_reg,
    input wire failed_reg,
    input wire xchg_en_reg,
    input wire [16:0] id_diag_reg,
    input wire [33:0] mod_status_reg
);
    // Fault and handshake terms
    wire flt = cfg_no_term | cfg_too_many | cfg_bus_fault;
    wire acc = out_valid_reg & out_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    chk_fail_entry: assert property (flt |=> failed_reg)
        else $error("failure not entered");
    chk_xchg_stop: assert property (failed_reg |-> !xchg_en_reg)
        else $error("exchange while failed");
    chk_id_bits: assert property (flt |=> id_diag_reg == 17'h1ffff)
        else $error("id bits not all set");
    chk_slot_codes: assert property (flt |=> mod_status_reg[33:32] == 2'h3 &&
        mod_status_reg[1:0] == (($past(fail_slot) > 5'h01) ? 2'h1 : 2'h3))
        else $error("slot status codes wrong");
    chk_off_step: assert property (acc && !out_last_reg |=>
        out_valid_reg && out_off_reg == $past(out_off_reg) + 8'h01)
        else $error("offset gap");
    chk_done_pulse: assert property (acc && out_last_reg |=> frame_done_reg && !out_valid_reg)
        else $error("frame end wrong");
    chk_irq_span: assert property (out_valid_reg && out_off_reg >= irq_start_reg |->
        out_off_reg - irq_start_reg < 8'h30)
        else $error("section too long");
    chk_proc_zero: assert property (out_valid_reg && irq_pend && irq_type == 2'h2 && irq_dig8 &&
        (out_off_reg == irq_start_reg + 8'h06 || out_off_reg == irq_start_reg + 8'h07)
        |-> out_byte_reg == 8'h00)
        else $error("process bytes not zero");
    // Main scenarios reached
    cover property (acc && out_last_reg);
    cover property (flt);
    cover property (out_valid_reg && !out_ready);
endmodule // sdif_checker

/* testbench/sdif_sink.sv */
// Purpose: stalling byte sink in place of the bus master
// Assumes: bytes arrive with their frame offset
// Notes: refuses one cycle in four
`timescale 1ns/10ps
module sdif_sink (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Byte stream
    input wire out_valid_reg,
    input wire [7:0] out_byte_reg,
    input wire [7:0] out_off_reg,
    output reg out_ready = 1'b0
);
    reg [7:0] mem [0:255];
    reg [1:0] cnt = 2'h0;
    integer n = 0;
    // Store accepted bytes by offset, stalling now and then
    always @(posedge clock) begin
        cnt <= cnt + 2'h1;
        out_ready <= nrst && (cnt != 2'h2);
        if (out_valid_reg && out_ready) begin
            mem[out_off_reg] <= out_byte_reg;
            n <= n + 1;
        end
    end
endmodule // sdif_sink

/* testbench/test_sdif_framer.sv */
// Purpose: self-checking bench for sdif_framer
// Assumes: records and entries are loaded before the first frame
// Notes: sampling is done on the falling edge
`timescale 1ns/10ps
module test_sdif_framer;
    // Stimulus
    reg clock, nrst, frame_req, chan_wr, rec_wr, irq_pend, irq_dig8, xchg_restart;
    reg cfg_no_term, cfg_too_many, cfg_bus_fault, master_new_cfg, master_conn_lost, master_off;
    reg [7:0] id_end_off, chan_base, rec_wr_data, irq_slot, irq_spec;
    reg [23:0] chan_wr_data;
    reg [4:0] chan_pending, fail_slot;
    reg [5:0] rec_wr_idx;
    reg [3:0] chan_wr_idx;
    reg [1:0] irq_type;
    reg [16:0] id_diag_in;
    reg [33:0] mod_status_in;
    // Observed
    wire out_ready, out_valid_reg, out_last_reg, frame_done_reg, irq_sent_reg;
    wire failed_reg, xchg_en_reg, cfg_fault_reg, diag_overflow_reg;
    wire [7:0] out_byte_reg, out_off_reg, irq_start_reg;
    wire [3:0] chan_count_reg;
    wire [16:0] id_diag_reg;
    wire [33:0] mod_status_reg;
    integer num_errors = 0, total_checks = 0, nb, i;
    sdif_framer sdif_framer_i (
        .clock(clock), .nrst(nrst), .frame_req(frame_req), .id_end_off(id_end_off),
        .chan_base(chan_base), .chan_wr(chan_wr), .chan_wr_idx(chan_wr_idx),
        .chan_wr_data(chan_wr_data), .chan_pending(chan_pending), .rec_wr(rec_wr),
        .rec_wr_idx(rec_wr_idx), .rec_wr_data(rec_wr_data), .irq_pend(irq_pend),
        .irq_type(irq_type), .irq_slot(irq_slot), .irq_spec(irq_spec), .irq_dig8(irq_dig8),
        .cfg_no_term(cfg_no_term), .cfg_too_many(cfg_too_many),
        .cfg_bus_fault(cfg_bus_fault), .fail_slot(fail_slot), .id_diag_in(id_diag_in),
        .mod_status_in(mod_status_in), .master_new_cfg(master_new_cfg),
        .master_conn_lost(master_conn_lost), .master_off(master_off),
        .xchg_restart(xchg_restart), .out_ready(out_ready), .out_valid_reg(out_valid_reg),
        .out_byte_reg(out_byte_reg), .out_off_reg(out_off_reg), .out_last_reg(out_last_reg),
        .frame_done_reg(frame_done_reg), .irq_sent_reg(irq_sent_reg),
        .irq_start_reg(irq_start_reg), .chan_count_reg(chan_count_reg),
        .diag_overflow_reg(diag_overflow_reg), .failed_reg(failed_reg),
        .xchg_en_reg(xchg_en_reg), .cfg_fault_reg(cfg_fault_reg),
        .id_diag_reg(id_diag_reg), .mod_status_reg(mod_status_reg));
    sdif_sink sdif_sink_i (.clock(clock), .nrst(nrst), .out_valid_reg(out_valid_reg),
        .out_byte_reg(out_byte_reg), .out_off_reg(out_off_reg), .out_ready(out_ready));
    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task chk(input string nm, input [35:0] exp, input [35:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task end_sim;
        begin
            $display("errors %0d checks %0d", num_errors, total_checks);
            if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task run_frame(input p, input [1:0] t, input d, input [4:0] np, input [7:0] cb,
        input [7:0] enb, input [7:0] est);
        integer k, n0;
        begin
            @(posedge clock);
            {irq_pend, irq_type, irq_dig8, chan_pending, chan_base} <= {p, t, d, np, cb};
            frame_req <= 1'b1;
            @(posedge clock);
            frame_req <= 1'b0;
            n0 = sdif_sink_i.n;
            k = 0;
            @(negedge clock);
            while (frame_done_reg !== 1'b1 && k < 500) begin
                @(negedge clock);
                k = k + 1;
            end
            if (k == 500) begin
                num_errors = num_errors + 1;
                end_sim;
            end else begin
                nb = sdif_sink_i.n - n0;
                chk("bytes", enb, nb);
                chk("start", est, irq_start_reg);
                chk("sent", p, irq_sent_reg);
            end
        end
    endtask
    task t_layout;
        begin
            run_frame(1'b1, 2'h0, 1'b0, 5'h03, 8'h13, 8'h39, 8'h1c);
            chk("entry", 8'hc0, sdif_sink_i.mem[8'h13]);
            chk("head", 8'ha0, sdif_sink_i.mem[8'h20]);
            chk("tail", 8'hcb, sdif_sink_i.mem[8'h4b]);
        end
    endtask
    task t_kinds;
        begin
            run_frame(1'b1, 2'h1, 1'b0, 5'h00, 8'h13, 8'h08, 8'h10);
            run_frame(1'b1, 2'h3, 1'b0, 5'h00, 8'h13, 8'h09, 8'h10);
            run_frame(1'b1, 2'h2, 1'b1, 5'h00, 8'h13, 8'h08, 8'h10);
            chk("x6", 8'h00, {sdif_sink_i.mem[8'h16], sdif_sink_i.mem[8'h17]});
        end
    endtask
    task t_reduce;
        begin
            run_frame(1'b1, 2'h0, 1'b0, 5'h0c, 8'hb4, 8'h3f, 8'hc3);
            chk("count", 4'h5, chan_count_reg);
            chk("ovf", 1'b1, diag_overflow_reg);
        end
    endtask
    task t_cfg;
        begin
            @(posedge clock);
            cfg_too_many <= 1'b1;
            @(posedge clock);
            @(negedge clock);
            chk("id", 17'h1ffff, id_diag_reg);
            chk("status", 34'h3ffffffd5, mod_status_reg);
            chk("fail", 3'h6, {failed_reg, cfg_fault_reg, xchg_en_reg});
            run_frame(1'b1, 2'h1, 1'b0, 5'h00, 8'h13, 8'h08, 8'h10);
            @(posedge clock);
            {cfg_too_many, xchg_restart} <= 2'h1;
            @(posedge clock);
            xchg_restart <= 1'b0;
            @(negedge clock);
            chk("clear", 2'h1, {failed_reg, xchg_en_reg});
            chk("id pass", 17'h00005, id_diag_reg);
            chk("st pass", 34'h0, mod_status_reg);
        end
    endtask
    task t_events;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                @(posedge clock);
                {cfg_no_term, cfg_too_many, cfg_bus_fault, master_new_cfg, master_conn_lost,
                    master_off} <= 6'h01 << i;
                @(posedge clock);
                {cfg_no_term, cfg_too_many, cfg_bus_fault, master_new_cfg, master_conn_lost,
                    master_off} <= 6'h00;
                @(negedge clock);
                chk("entry", 2'h2, {failed_reg, xchg_en_reg});
                @(posedge clock);
                xchg_restart <= 1'b1;
                @(posedge clock);
                xchg_restart <= 1'b0;
                @(negedge clock);
                chk("restart", 2'h1, {failed_reg, xchg_en_reg});
            end
        end
    endtask
    // Main sequence
    initial begin
        {frame_req, chan_wr, rec_wr, irq_pend, irq_dig8, xchg_restart, cfg_no_term,
            cfg_too_many, cfg_bus_fault, master_new_cfg, master_conn_lost, master_off} = '0;
        {chan_base, rec_wr_data, irq_slot, irq_spec, chan_wr_data, chan_pending} = '0;
        {rec_wr_idx, chan_wr_idx, irq_type, mod_status_in} = '0;
        {id_end_off, fail_slot, id_diag_in} = {8'h10, 5'h04, 17'h00005};
        nrst = 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        for (i = 0; i < 44; i = i + 1) begin
            @(posedge clock);
            {rec_wr, rec_wr_idx, rec_wr_data} <= {1'b1, i[5:0], 8'ha0 + i[7:0]};
            {chan_wr, chan_wr_idx} <= {i < 9, i[3:0]};
            chan_wr_data <= {8'hc0 + i[7:0], 8'hd0 + i[7:0], 8'he0 + i[7:0]};
        end
        @(posedge clock);
        {rec_wr, chan_wr} <= 2'h0;
        t_layout;
        t_kinds;
        t_reduce;
        t_cfg;
        t_events;
        end_sim;
    end
endmodule // test_sdif_framer
bind sdif_framer sdif_checker sdif_checker_i (
    .clock(clock), .nrst(nrst), .out_ready(out_ready), .irq_pend(irq_pend),
    .irq_type(irq_type), .irq_dig8(irq_dig8), .cfg_no_term(cfg_no_term),
    .cfg_too_many(cfg_too_many), .cfg_bus_fault(cfg_bus_fault), .fail_slot(fail_slot),
    .out_valid_reg(out_valid_reg), .out_byte_reg(out_byte_reg), .out_off_reg(out_off_reg),
    .out_last_reg(out_last_reg), .frame_done_reg(frame_done_reg),
    .irq_start_reg(irq_start_reg), .failed_reg(failed_reg), .xchg_en_reg(xchg_en_reg),
    .id_diag_reg(id_diag_reg), .mod_status_reg(mod_status_reg));
